// ===== core/tfa_regs.svh
// constants for the transport frame line adapter: byte indices, fill values, slot layout
// assumes byte index 0 is the error byte, so frame byte Bk sits at index k+8
// Notes on behaviour
// - junction frame holds N times 24 bytes
// - bit clock travels apart from the data
// - frame bytes pass unchanged, no added protection
// - junction transmit clock echoes receive clock
// - N must be big enough for payload
// - slot bus mode uses one 384 kbit/s slot
// - slot bus frame is 1152 bytes
// - slot bus data layer counts eight streams
// - byte 44 bit 0 starts the slot
// - aligned bit may open first data stream
// - audio link uses every subframe, 3072 kbit/s
// - audio frame is 4608 bytes
// - audio payload only in timeslots 12 to 27
// - no fixed audio to frame alignment
// - audio validity bit always one
// - sync word alternates with its complement
// - unused bytes are filled with 55 hex
`ifndef TFA_REGS_SVH
`define TFA_REGS_SVH

// -----------------------------------------------------------------
// frame layout
// -----------------------------------------------------------------
`define TFA_BYTES_PER_N     13'h0018
`define TFA_TFL_SLOT_BUS    13'h0480
`define TFA_TFL_AUDIO       13'h1200
`define TFA_IDX_FRAME_SYNC_WORD_FIRST 13'h0001
`define TFA_IDX_FRAME_SYNC_WORD_LAST  13'h0003
`define TFA_IDX_DFS_HI      13'h0004
`define TFA_IDX_DFS_LO      13'h0005
`define TFA_IDX_SLOT_ALIGN  13'h0034
`define TFA_FRAME_SYNC_WORD_B0        8'h1F
`define TFA_FRAME_SYNC_WORD_B1        8'h90
`define TFA_FRAME_SYNC_WORD_B2        8'hCA
`define TFA_PAD_BYTE        8'h55
`define TFA_STREAM_COUNT    4'h8

// -----------------------------------------------------------------
// audio subframe layout
// -----------------------------------------------------------------
`define TFA_SLOT_PRE_LAST   5'h03
`define TFA_SLOT_AUX_FIRST  5'h04
`define TFA_SLOT_DATA_FIRST 5'h0C
`define TFA_SLOT_DATA_LAST  5'h1B
`define TFA_SLOT_VALID      5'h1C
`define TFA_SLOT_USER       5'h1D
`define TFA_SLOT_STATUS     5'h1E
`define TFA_SLOT_PARITY     5'h1F
`define TFA_FRAME_LAST      8'hBF

`endif

// ===== core/tfa_pkg.sv
// types shared by the transport frame line adapter
// assumes the constants header is included by the design files
package tfa_pkg;
  // line carrier selection
  typedef enum logic [1:0] {
    MODE_JUNC  = 2'b00,
    MODE_SLOT  = 2'b01,
    MODE_AUDIO = 2'b10
  } tfa_mode_type;
  // audio preamble kind, coded by the line driver
  typedef enum logic [1:0] {
    PRE_BLOCK = 2'b00,
    PRE_FIRST = 2'b01,
    PRE_SECOND = 2'b10
  } tfa_pre_type;
endpackage

// ===== core/tfa_byte_if.sv
// byte hand-off between the line bit engine and the frame byte sequencer
// assumes both ends run on the one system clock
`timescale 1ns/10ps
`default_nettype none
interface tfa_byte_if;
  logic        take;        // engine consumes byte_val this cycle
  logic        realign;     // slot sync seen, jump to aligned byte
  logic [12:0] transport_frame_length;         // frame length in bytes
  logic [7:0]  byte_val;    // byte at the current index
  logic        frame_start; // current index is the error byte
  logic        dfs_nz;      // data frame present in this frame
  modport seq (input take, realign, transport_frame_length, output byte_val, frame_start, dfs_nz);
  modport eng (output take, realign, transport_frame_length, input byte_val, frame_start, dfs_nz);
endinterface
`default_nettype wire

// ===== core/tfa_byte_seq.sv
// frame byte sequencer: sync word, source bytes, padding, frame wrap
// assumes the source holds its byte stable until the acknowledge pulse
`timescale 1ns/10ps
`include "tfa_regs.svh"
`default_nettype none
module tfa_byte_seq (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // byte source
  input  wire logic [7:0] i_src_byte,
  input  wire logic       i_src_valid,
  input  wire logic       i_src_last,
  output logic            o_src_ack,
  // engine side
  tfa_byte_if.seq         bif
);
  logic [12:0] idx;      // index of the next byte, error byte is 0
  logic        phase;    // sync word polarity of this frame
  logic        src_done; // source gave its last byte this frame
  logic        dfs_hi;   // high size byte was nonzero
  logic        dfs_nz;

  // -----------------------------------------------------------------
  // byte selection
  // -----------------------------------------------------------------
  wire       in_frame_sync_word = (idx >= `TFA_IDX_FRAME_SYNC_WORD_FIRST) && (idx <= `TFA_IDX_FRAME_SYNC_WORD_LAST);
  wire [7:0] fs_raw   = (idx[1:0] == 2'h1) ? `TFA_FRAME_SYNC_WORD_B0 :
                        (idx[1:0] == 2'h2) ? `TFA_FRAME_SYNC_WORD_B1 : `TFA_FRAME_SYNC_WORD_B2;
  wire [7:0] fs_byte  = fs_raw ^ {8{phase}};
  wire       use_src  = !in_frame_sync_word && !src_done && i_src_valid;
  wire       last_idx = idx >= (bif.transport_frame_length - 13'h0001);
  // source bytes go out untouched, gaps and tail become fill
  assign bif.byte_val    = in_frame_sync_word ? fs_byte : (use_src ? i_src_byte : `TFA_PAD_BYTE);
  assign bif.frame_start = (idx == 13'h0000);
  assign bif.dfs_nz      = dfs_nz;

  // index walk: ascending, wrap at frame length, slot sync forces alignment
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx   <= 13'h0000;
      phase <= 1'b0;
    end else if (bif.realign) begin
      idx <= `TFA_IDX_SLOT_ALIGN;
    end else if (bif.take) begin
      idx <= last_idx ? 13'h0000 : idx + 13'h0001;
      if (last_idx) begin
        phase <= ~phase;
      end
    end
  end

  // source bookkeeping and data frame presence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_done  <= 1'b0;
      o_src_ack <= 1'b0;
      dfs_hi    <= 1'b0;
      dfs_nz    <= 1'b0;
    end else begin
      o_src_ack <= bif.take && use_src;
      if (bif.take && last_idx) begin
        src_done <= 1'b0;
      end else if (bif.take && use_src && i_src_last) begin
        src_done <= 1'b1;
      end
      if (bif.take && idx == `TFA_IDX_DFS_HI) begin
        dfs_hi <= |bif.byte_val;
      end
      if (bif.take && idx == `TFA_IDX_DFS_LO) begin
        dfs_nz <= dfs_hi || (|bif.byte_val);
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic [7:0]  prev_fs;   // first sync byte of the previous frame
  logic        fs_seen;
  logic [12:0] cnt;       // bytes taken since the frame began
  logic        clean;     // no realign in this frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_fs <= 8'h00;
      fs_seen <= 1'b0;
      cnt     <= 13'h0000;
      clean   <= 1'b0;
    end else begin
      if (bif.take && idx == `TFA_IDX_FRAME_SYNC_WORD_FIRST) begin
        prev_fs <= bif.byte_val;
        fs_seen <= 1'b1;
      end
      if (bif.realign) begin
        clean <= 1'b0;
      end else if (bif.take && last_idx) begin
        cnt   <= 13'h0000;
        clean <= 1'b1;
      end else if (bif.take) begin
        cnt <= cnt + 13'h0001;
      end
    end
  end

  frame_sync_word_alt_a: assert property (@(posedge clk) disable iff (rst)
    bif.take && idx == `TFA_IDX_FRAME_SYNC_WORD_FIRST && fs_seen |-> bif.byte_val == ~prev_fs)
    else $error("sync word did not alternate");
  pad_fill_a: assert property (@(posedge clk) disable iff (rst)
    bif.take && src_done && !in_frame_sync_word |-> bif.byte_val == `TFA_PAD_BYTE)
    else $error("fill byte is not 55 hex");
  payload_pass_a: assert property (@(posedge clk) disable iff (rst)
    bif.take && use_src |-> bif.byte_val == i_src_byte ##1 o_src_ack)
    else $error("payload byte altered or not acknowledged");
  frame_len_a: assert property (@(posedge clk) disable iff (rst)
    bif.take && last_idx && clean && !bif.realign |-> cnt + 13'h0001 == bif.transport_frame_length)
    else $error("frame length differs from configured length");
  frame_wrap_c: cover property (@(posedge clk) disable iff (rst) bif.take && last_idx && clean);
endmodule
`default_nettype wire

// ===== core/tfa_transport_framer.sv
// transport frame line adapter: serialises frames onto junction, slot bus or audio link
// assumes config inputs are static while framing and come from the I_CLK domain
`timescale 1ns/10ps
`include "tfa_regs.svh"
`default_nettype none
module tfa_transport_framer #(
  parameter logic [191:0] CS_TABLE = 192'h0 // channel status per audio frame, bit i = frame i
) (
  // clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  // configuration
  input  wire logic [1:0] I_MODE,
  input  wire logic [7:0] I_RATE_N,
  // line side
  input  wire logic       I_LINE_CLK,
  input  wire logic       I_SLOT_SYNC,
  output logic            O_TX_CLK,
  output logic            O_LINE_DATA,
  output logic            O_PREAMBLE,
  output logic [1:0]      O_PREAMBLE_KIND,
  output logic            O_FRAME_START,
  output logic [3:0]      O_STREAM_COUNT,
  // frame source
  input  wire logic [7:0] I_SRC_BYTE,
  input  wire logic       I_SRC_VALID,
  input  wire logic       I_SRC_LAST,
  output logic            O_SRC_ACK
);
  tfa_byte_if bif ();

  // -----------------------------------------------------------------
  // frame length
  // -----------------------------------------------------------------
  // N of zero would give an empty frame, so it is run as N = 1
  function automatic logic [12:0] calc_tfl(input tfa_pkg::tfa_mode_type m, input logic [7:0] n);
    logic [12:0] nn;
    nn = (n == 8'h00) ? 13'h0001 : {5'h00, n};
    case (m)
      tfa_pkg::MODE_SLOT:  calc_tfl = `TFA_TFL_SLOT_BUS;
      tfa_pkg::MODE_AUDIO: calc_tfl = `TFA_TFL_AUDIO;
      default:             calc_tfl = 13'(nn * `TFA_BYTES_PER_N);
    endcase
  endfunction

  wire tfa_pkg::tfa_mode_type mode = tfa_pkg::tfa_mode_type'(I_MODE);
  wire mode_slot  = (mode == tfa_pkg::MODE_SLOT);
  wire mode_audio = (mode == tfa_pkg::MODE_AUDIO);
  // the spare code 11 runs as junction, as calc_tfl already does
  wire mode_junc  = !mode_slot && !mode_audio;
  assign bif.transport_frame_length  = calc_tfl(mode, I_RATE_N);

  // -----------------------------------------------------------------
  // link clock sampling
  // -----------------------------------------------------------------
  logic lclk_s1;  // first stage, read only by lclk_s2
  logic lclk_s2;
  logic lclk_d;   // previous synchronised level, for edge finding
  logic sync_s1;  // first stage, read only by sync_s2
  logic sync_s2;
  // the link clock is just sampled; it is far slower than I_CLK
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_d  <= 1'b0;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
    end else begin
      lclk_s1 <= I_LINE_CLK;
      lclk_s2 <= lclk_s1;
      lclk_d  <= lclk_s2;
      sync_s1 <= I_SLOT_SYNC;
      sync_s2 <= sync_s1;
    end
  end

  // bits change on the falling edge so the far end samples on the rising one
  wire lclk_fall = !lclk_s2 && lclk_d;

  // -----------------------------------------------------------------
  // bit engine
  // -----------------------------------------------------------------
  logic [7:0] sr;       // byte being sent
  logic [2:0] bit_cnt;  // next bit of sr, 0 means load a new byte
  logic       pend;     // aligned byte loads one cycle after the sync hit
  logic [4:0] slot;     // audio timeslot of the bit now being sent
  logic       sub;      // audio subframe within frame
  logic [7:0] aframe;   // audio frame within block
  logic       par;      // running parity over timeslots 4 to 30

  wire slot_hit  = mode_slot && lclk_fall && sync_s2;
  wire data_slot = (slot >= `TFA_SLOT_DATA_FIRST) && (slot <= `TFA_SLOT_DATA_LAST);
  wire adv       = lclk_fall && !slot_hit && (!mode_audio || data_slot);
  assign bif.realign = slot_hit;
  assign bif.take    = pend || (adv && bit_cnt == 3'h0);

  // bit 0 first: a fresh byte sends its bit 0 at once
  wire next_data_bit = bif.take ? bif.byte_val[0] : sr[bit_cnt];

  // audio timeslot content; preamble slots are left low for the line coder
  logic aud_bit;
  always_comb begin
    aud_bit = 1'b0;
    if (data_slot) begin
      aud_bit = next_data_bit;
    end else if (slot == `TFA_SLOT_VALID) begin
      aud_bit = 1'b1;
    end else if (slot == `TFA_SLOT_STATUS) begin
      aud_bit = CS_TABLE[aframe];
    end else if (slot == `TFA_SLOT_PARITY) begin
      aud_bit = par;
    end
  end

  wire emit      = mode_audio ? lclk_fall : (adv || pend);
  wire next_line = mode_audio ? aud_bit : next_data_bit;

  // byte register and bit counter
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sr      <= 8'h00;
      bit_cnt <= 3'h0;
      pend    <= 1'b0;
    end else begin
      pend <= slot_hit;
      if (bif.take) begin
        sr      <= bif.byte_val;
        bit_cnt <= 3'h1;
      end else if (adv) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // audio position counters; they free-run with no tie to frame start
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      slot   <= 5'h00;
      sub    <= 1'b0;
      aframe <= 8'h00;
      par    <= 1'b0;
    end else if (mode_audio && lclk_fall) begin
      slot <= slot + 5'h01;
      if (slot == `TFA_SLOT_AUX_FIRST) begin
        par <= aud_bit;
      end else if (slot < `TFA_SLOT_PARITY) begin
        par <= par ^ aud_bit;
      end
      if (slot == `TFA_SLOT_PARITY) begin
        sub <= ~sub;
        if (sub) begin
          aframe <= (aframe == `TFA_FRAME_LAST) ? 8'h00 : aframe + 8'h01;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  // junction transmit clock is the sampled receive clock, so it lags by three cycles; other modes hold it low
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TX_CLK        <= 1'b0;
      O_LINE_DATA     <= 1'b0;
      O_PREAMBLE      <= 1'b0;
      O_PREAMBLE_KIND <= tfa_pkg::PRE_BLOCK;
      O_FRAME_START   <= 1'b0;
      O_STREAM_COUNT  <= 4'h0;
    end else begin
      O_TX_CLK <= mode_junc && lclk_s2;
      if (emit) begin
        O_LINE_DATA <= next_line;
      end
      if (mode_audio && lclk_fall) begin
        O_PREAMBLE      <= (slot <= `TFA_SLOT_PRE_LAST);
        O_PREAMBLE_KIND <= sub ? tfa_pkg::PRE_SECOND :
                           (aframe == 8'h00) ? tfa_pkg::PRE_BLOCK : tfa_pkg::PRE_FIRST;
      end else if (!mode_audio) begin
        O_PREAMBLE <= 1'b0;
      end
      O_FRAME_START  <= bif.take && bif.frame_start;
      O_STREAM_COUNT <= (mode_slot && bif.dfs_nz) ? `TFA_STREAM_COUNT : 4'h0;
    end
  end

  tfa_byte_seq u_seq (
    .clk         (I_CLK),
    .rst         (I_RST),
    .i_src_byte  (I_SRC_BYTE),
    .i_src_valid (I_SRC_VALID),
    .i_src_last  (I_SRC_LAST),
    .o_src_ack   (O_SRC_ACK),
    .bif         (bif)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // edges since reset; the echo check waits out the sampler fill,
  // since the sampler resets low while an idle line clock sits high
  logic [2:0] echo_age;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      echo_age <= 3'h0;
    end else if (echo_age != 3'h4) begin
      echo_age <= echo_age + 3'h1;
    end
  end

  // parity rebuilt from the line output itself, apart from par above
  logic       aud_emit_d; // a timeslot bit reached the line last edge
  logic [4:0] slot_d;     // timeslot of that bit
  logic       line_par;   // xor of sent bits from timeslot 4 on
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      aud_emit_d <= 1'b0;
      slot_d     <= 5'h00;
      line_par   <= 1'b0;
    end else begin
      aud_emit_d <= mode_audio && lclk_fall;
      slot_d     <= slot;
      if (aud_emit_d && slot_d == `TFA_SLOT_AUX_FIRST) begin
        line_par <= O_LINE_DATA;
      end else if (aud_emit_d && slot_d < `TFA_SLOT_PARITY) begin
        line_par <= line_par ^ O_LINE_DATA;
      end
    end
  end

  tx_clk_echo_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_junc && echo_age == 3'h4 |-> O_TX_CLK == $past(I_LINE_CLK, 3))
    else $error("transmit clock is not the receive clock echo");
  validity_one_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_audio && lclk_fall && slot == `TFA_SLOT_VALID |=> O_LINE_DATA)
    else $error("validity bit not one");
  data_slots_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_audio && bif.take |-> data_slot && lclk_fall)
    else $error("payload byte taken outside timeslots 12 to 27");
  slot_align_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    slot_hit |=> pend ##1 (bit_cnt == 3'h1 && O_LINE_DATA == sr[0]))
    else $error("aligned byte not started at slot sync");
  bit_order_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    !mode_audio && bif.take |=> O_LINE_DATA == $past(bif.byte_val[0]))
    else $error("byte not sent bit 0 first");
  slot_len_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_slot |-> bif.transport_frame_length == `TFA_TFL_SLOT_BUS)
    else $error("slot bus frame length wrong");
  stream_cnt_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_slot && bif.dfs_nz |=> O_STREAM_COUNT == `TFA_STREAM_COUNT)
    else $error("stream count not eight");
  audio_len_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_audio |-> bif.transport_frame_length == `TFA_TFL_AUDIO)
    else $error("audio frame length wrong");

  // no transmit clock leaves outside junction mode
  tx_clk_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    !mode_junc |=> !O_TX_CLK)
    else $error("transmit clock runs outside junction mode");

  // frame start marks one byte load only
  start_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_FRAME_START |=> !O_FRAME_START)
    else $error("frame start longer than one cycle");

  // one acknowledge per consumed source byte
  ack_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_SRC_ACK |=> !O_SRC_ACK)
    else $error("source acknowledge longer than one cycle");

  // stream count shows only on the slot bus
  stream_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    !mode_slot |=> O_STREAM_COUNT == 4'h0)
    else $error("stream count outside slot bus mode");

  // payload bytes start at timeslot 12 or 20 of a subframe
  audio_bytes_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_audio && bif.take |-> slot == `TFA_SLOT_DATA_FIRST || slot == 5'h14)
    else $error("payload byte not aligned in subframe");

  // preamble, aux and user slots carry no payload
  quiet_slots_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    aud_emit_d && (slot_d < `TFA_SLOT_DATA_FIRST || slot_d == `TFA_SLOT_USER) |-> !O_LINE_DATA)
    else $error("non payload timeslot not zero");

  // channel status follows the table by audio frame
  status_table_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    aud_emit_d && slot_d == `TFA_SLOT_STATUS |-> O_LINE_DATA == CS_TABLE[aframe])
    else $error("channel status bit differs from table");

  // sent subframe has even parity over timeslots 4 to 31
  parity_even_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    aud_emit_d && slot_d == `TFA_SLOT_PARITY |-> O_LINE_DATA == line_par)
    else $error("subframe parity not even");

  realign_c: cover property (@(posedge I_CLK) disable iff (I_RST) slot_hit ##2 bit_cnt == 3'h1);
  block_c: cover property (@(posedge I_CLK) disable iff (I_RST)
    mode_audio && lclk_fall && slot == 5'h00 && aframe == 8'h00 && !sub);
  junc_start_c: cover property (@(posedge I_CLK) disable iff (I_RST) mode_junc && O_FRAME_START);
  parity_c: cover property (@(posedge I_CLK) disable iff (I_RST)
    aud_emit_d && slot_d == `TFA_SLOT_PARITY);
endmodule
`default_nettype wire

// ===== sim/tfa_line_partner.sv
// line equipment model: bit clock on its own circuit and slot sync pulses
// assumes the bench starts the clock only after reset is released
`timescale 1ns/10ps
`default_nettype none
module tfa_line_partner #(
  parameter int HALF_NS = 40 // half of the 80 ns bit period
) (
  // requests from the bench
  input  wire logic i_run,
  input  wire logic i_sync_req,
  // line side
  output logic      o_line_clk,
  output logic      o_slot_sync
);
  // ---------------------------------------------------------------
  // bit clock, apart from data, idle high while stopped
  // ---------------------------------------------------------------
  // a synchronous network clock runs free while the link is up
  initial begin
    o_line_clk = 1'b1;
    #3;
    forever begin
      #HALF_NS;
      o_line_clk = i_run ? ~o_line_clk : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // slot sync: one pulse straddling one falling edge
  // ---------------------------------------------------------------
  // our slot is one of up to sixteen on the bus; the others are idle
  initial o_slot_sync = 1'b0;
  always @(posedge i_sync_req) begin
    @(posedge o_line_clk);
    #(HALF_NS / 2) o_slot_sync = 1'b1;
    #HALF_NS o_slot_sync = 1'b0;
  end
endmodule
`default_nettype wire

// ===== sim/tfa_transport_framer_test.sv
// self-checking bench for the transport frame line adapter
// assumes the line partner model and the design files are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end \
  end
module tfa_transport_framer_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic       clk, rst, run, sync_req, jchk;
  logic [1:0] mode, pre_kind, bit_k;
  logic [7:0] rate_n, src_byte, src_ptr;
  logic       line_clk, slot_sync, tx_clk, line_data, pre, frame_start;
  logic [3:0] stream_count;
  logic       src_valid, src_last, src_ack, bit_p;
  logic [7:0] src_mem [0:255]; // source byte stream
  int         last_at, n_errors, samples_checked;

  tfa_transport_framer u_dut (.I_CLK(clk), .I_RST(rst), .I_MODE(mode), .I_RATE_N(rate_n),
    .I_LINE_CLK(line_clk), .I_SLOT_SYNC(slot_sync), .O_TX_CLK(tx_clk),
    .O_LINE_DATA(line_data), .O_PREAMBLE(pre), .O_PREAMBLE_KIND(pre_kind),
    .O_FRAME_START(frame_start), .O_STREAM_COUNT(stream_count), .I_SRC_BYTE(src_byte),
    .I_SRC_VALID(src_valid), .I_SRC_LAST(src_last), .O_SRC_ACK(src_ack));
  tfa_line_partner u_partner (.i_run(run), .i_sync_req(sync_req), .o_line_clk(line_clk),
    .o_slot_sync(slot_sync));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // next source byte only once the ack has been seen
  always @(posedge clk) begin
    if (src_ack === 1'b1) begin
      src_ptr  <= src_ptr + 8'h01;
      src_byte <= src_mem[src_ptr + 8'h01];
      src_last <= (src_ptr + 8'h01 == last_at);
    end
  end

  // transmit clock follows the receive clock three cycles late
  always @(line_clk) begin
    if (jchk) begin
      repeat (3) @(posedge clk);
      #1 if (jchk) `CHK("tx clock echo", line_clk, tx_clk);
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // mode is static, so each scenario starts from its own reset
  task automatic do_reset(input logic [1:0] m, input logic v);
    @(posedge clk);
    rst <= 1'b1;
    run <= 1'b0;
    mode <= m;
    src_valid <= v;
    src_ptr <= 8'h00;
    src_byte <= src_mem[0];
    src_last <= 1'b0;
    repeat (8) @(posedge clk);
    #1 `CHK("outputs in reset", 11'h000, {tx_clk, line_data, pre, pre_kind, frame_start,
      stream_count, src_ack});
    @(posedge clk) rst <= 1'b0;
    repeat (3) @(posedge clk);
    run <= 1'b1;
  endtask

  // one line bit, taken well after the update that follows a fall
  task automatic get_bit(output logic d);
    @(negedge line_clk);
    repeat (5) @(posedge clk);
    #1 d = line_data;
    bit_p = pre;
    bit_k = pre_kind;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // junction, N of 1: two frames, source ends early in the second
  task automatic test_junction();
    logic [7:0] got, exp;
    logic       d;
    int         n, j;
    for (int i = 0; i < 256; i++) src_mem[i] = 8'(i * 29 + 19);
    last_at = 30;
    do_reset(tfa_pkg::MODE_JUNC, 1'b1); // twenty-one source bytes fit in each frame at N of 1, index 0 included
    jchk = 1'b1;
    n = 0;
    while (frame_start !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("frame start", 1'b1, frame_start);
    @(posedge clk);
    #1 d = line_data;
    for (int k = 0; k < 48; k++) begin
      for (int b = 0; b < 8; b++) begin
        if (k + b > 0) get_bit(d);
        got[b] = d;
      end
      j = k % 24;
      if (j == 1) exp = (k < 24) ? 8'h1F : 8'hE0;
      else if (j == 2) exp = (k < 24) ? 8'h90 : 8'h6F;
      else if (j == 3) exp = (k < 24) ? 8'hCA : 8'h35;
      else if (k < 24) exp = src_mem[(j == 0) ? 0 : j - 3];
      else if (j == 0) exp = src_mem[21];
      else if (j <= 12) exp = src_mem[18 + j];
      else exp = 8'h55;
      `CHK("junction byte", exp, got);
    end
    `CHK("bytes taken", 8'h1F, src_ptr);
    jchk = 1'b0;
  endtask

  // slot bus: size field nonzero, then a sync pulse off a byte boundary
  task automatic test_slot();
    logic [7:0] got;
    logic       d;
    for (int i = 0; i < 256; i++) src_mem[i] = 8'hFE;
    src_mem[0] = 8'h00;
    src_mem[1] = 8'h00;
    src_mem[2] = 8'h10;
    last_at = 255;
    do_reset(tfa_pkg::MODE_SLOT, 1'b1);
    repeat (83) get_bit(d);
    `CHK("stream count", 4'h8, stream_count);
    @(posedge clk) sync_req <= 1'b1;
    @(negedge slot_sync);
    @(posedge clk) sync_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1 got[0] = line_data;
    for (int b = 1; b < 8; b++) begin
      get_bit(d);
      got[b] = d;
    end
    `CHK("aligned byte", 8'hFE, got);
  endtask

  // audio: source idle, so payload is padding; two subframes inspected
  task automatic test_audio();
    logic [31:0] d [2];
    logic [31:0] p [2];
    logic [1:0]  k [2];
    logic        x;
    int          n;
    last_at = 255;
    do_reset(tfa_pkg::MODE_AUDIO, 1'b0);
    repeat (160) get_bit(x);
    n = 0;
    // slot 0 is found from the preamble mark, never assumed
    do begin
      get_bit(x);
      n++;
    end while (bit_p !== 1'b0 && n < 64);
    do begin
      get_bit(x);
      n++;
    end while (bit_p !== 1'b1 && n < 128);
    for (int s = 0; s < 64; s++) begin
      if (s > 0) get_bit(x);
      d[s / 32][s % 32] = x;
      p[s / 32][s % 32] = bit_p;
      if (s % 32 == 0) k[s / 32] = bit_k;
    end
    for (int h = 0; h < 2; h++) begin
      `CHK("preamble slots", 32'h0000000F, p[h]);
      `CHK("fixed slots", 32'h10000000, d[h] & 32'h70000FFF);
      `CHK("even parity", 1'b0, ^d[h][31:4]);
      `CHK("pad payload", 1'b1, (d[h][27:12] == 16'h5555) || (d[h][27:12] == 16'hAAAA));
    end
    `CHK("subframe order", 1'b1, (k[0] == 2'b10) != (k[1] == 2'b10));
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    mode = 2'b00;
    rate_n = 8'h01;
    run = 1'b0;
    sync_req = 1'b0;
    src_byte = 8'h00;
    src_valid = 1'b0;
    src_last = 1'b0;
    src_ptr = 8'h00;
    last_at = 255;
    jchk = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    test_junction();
    test_slot();
    test_audio();
    close_out();
  end

  // the scenarios need about 59 us of line time
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
